//--- hdl/mute_ctrl_pkg.sv
// Package: constants, states and carriers for the light curtain mute controller
package mute_ctrl_pkg;

    // Clock rate and prescaled tick
    localparam int unsigned CLK_HZ        = 125_000_000;
    localparam int unsigned TICK_HZ       = 8;
    localparam int unsigned TICK_CYCLES   = CLK_HZ / TICK_HZ;
    // Times in their own units
    localparam int unsigned MUTE_LIMIT_S  = 120;   // 2 minutes
    localparam int unsigned BYPASS_MAX_S  = 600;   // 10 minutes
    localparam int unsigned FLASH_HZ_X2   = 3;     // 1.5 Hz, times two
    // Tick counts derived from the times
    localparam int unsigned MUTE_LIMIT_TICKS = MUTE_LIMIT_S * TICK_HZ;
    localparam int unsigned BYPASS_MAX_TICKS = BYPASS_MAX_S * TICK_HZ;
    localparam int unsigned FLASH_HALF_TICKS = (TICK_HZ * 2 + FLASH_HZ_X2 * 2 - 1)
                                               / (FLASH_HZ_X2 * 2) ;
    localparam int unsigned TICK_CNT_W    = 24;
    localparam int unsigned STATE_CNT_W   = 13;

    // Diagnostic codes, two hex digits
    localparam logic [7:0] DIAG_RUN       = 8'h00;
    localparam logic [7:0] DIAG_MUTE      = 8'h02;
    localparam logic [7:0] DIAG_BYPASS    = 8'h03;
    localparam logic [7:0] DIAG_STOP      = 8'h01;
    localparam logic [7:0] DIAG_INTERLOCK = 8'h05;
    localparam logic [7:0] DIAG_LOCKOUT   = 8'h0F;

    // Interlock configuration
    typedef enum logic [1:0] {
        ILK_AUTO          = 2'h0,
        ILK_START         = 2'h1,
        ILK_START_RESTART = 2'h2
    } interlock_mode_e;

    // Controller states, one-hot; lockout uses the all-zero code
    typedef enum logic [6:0] {
        ST_POWERUP   = 7'h01,
        ST_INTERLOCK = 7'h02,
        ST_RUN       = 7'h04,
        ST_STOP      = 7'h08,
        ST_MUTE      = 7'h10,
        ST_BYPASS_OK = 7'h20,
        ST_BYPASS    = 7'h40
    } ctrl_state_e;
    localparam logic [6:0] ST_LOCKOUT_CODE = 7'h00;

    // Mute sensor sequencing states
    typedef enum logic [2:0] {
        SQ_IDLE  = 3'h1,
        SQ_FIRST = 3'h2,
        SQ_FAIL  = 3'h4
    } seq_state_e;
    localparam int unsigned SEQ_WINDOW_S      = 3;  // less than 3 s between sensors
    localparam int unsigned SEQ_WINDOW_TICKS  = SEQ_WINDOW_S * TICK_HZ;

    // Configuration carrier
    typedef struct packed {
        logic            mute_enable;
        logic            mute_limit_en;
        logic            directional;
        interlock_mode_e interlock;
    } config_s;

    // Indicator carrier
    typedef struct packed {
        logic run_green;
        logic stop_red;
        logic interlock_yellow;
        logic mute_lamp;
    } lamps_s;

endpackage

//--- hdl/light_curtain_mute_controller.sv
// Safety output state controller with muting, bypass and interlock
`timescale 1ns/1ps
module light_curtain_mute_controller #(
    parameter int unsigned CURTAINS   = 2,
    parameter int unsigned TICK_DIV   = mute_ctrl_pkg::TICK_CYCLES,
    parameter int unsigned FB_GRACE   = 4
) (
    input  wire logic                   ref_clk,
    input  wire logic                   rst_n,
    input  wire logic [CURTAINS-1:0]    light_curtain_in,
    input  wire logic [CURTAINS-1:0]    curtain_select,
    input  wire logic [1:0]             mute_sensor,
    input  wire logic                   start_button,
    input  wire logic                   contactor_feedback_monitor,
    input  wire mute_ctrl_pkg::config_s cfg,
    output logic [1:0]                  safety_switching_output,
    output mute_ctrl_pkg::lamps_s       lamps,
    output logic [7:0]                  diag_code,
    output logic                        lockout
);

    // Refuse sizes that the synchroniser, divider and grace counter cannot hold
    if (CURTAINS < 1 || CURTAINS > 8 || TICK_DIV < 2 || TICK_DIV >= (1 << 24)
        || FB_GRACE < 1 || FB_GRACE > 255) begin : g_bad_param
        $error("light_curtain_mute_controller: unsupported parameter");
    end

    // Two-flop synchronisers for the curtain, mute sensor, start and feedback inputs
    localparam int unsigned SW = CURTAINS + 4;
    logic [SW-1:0] sync1_q, sync2_q;
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            sync1_q <= '0;
            sync2_q <= '0;
        end else begin
            sync1_q <= {light_curtain_in, mute_sensor, start_button, contactor_feedback_monitor};
            sync2_q <= sync1_q;
        end
    end
    logic [CURTAINS-1:0] curt;
    logic [1:0]          msens;
    logic                start_s, fb_s;
    assign {curt, msens, start_s, fb_s} = sync2_q;

    // Curtain clear when every selected input is on
    logic curt_clear, sens_any, sens_all;
    assign curt_clear = &(curt | ~curtain_select);
    assign sens_any   = |msens;
    assign sens_all   = &msens;

    // Start edge detection: press then release
    logic start_prev_q, start_prev_d;
    logic start_rel;
    assign start_prev_d = start_s;
    assign start_rel    = start_prev_q & ~start_s;

    // Prescaled tick shared by the sequence window and state timers; the feedback grace counts clocks
    logic [23:0] div_q, div_d;
    logic        tick;
    always_comb begin
        tick  = (div_q == 24'(TICK_DIV - 1));
        div_d = tick ? 24'h000000 : div_q + 24'h000001;
    end

    // Mute sensor sequencing
    mute_ctrl_pkg::seq_state_e sq_q, sq_d;
    logic [12:0] sq_cnt_q, sq_cnt_d;
    logic        seq_ok, seq_fail;
    always_comb begin
        sq_d     = sq_q;
        sq_cnt_d = sq_cnt_q;
        seq_ok   = 1'b0;
        seq_fail = 1'b0;
        case (sq_q)
            mute_ctrl_pkg::SQ_IDLE: begin
                sq_cnt_d = 13'h0000;
                if (sens_all && !cfg.directional) begin
                    seq_ok = 1'b1;
                end else if (msens == 2'b01) begin
                    sq_d = mute_ctrl_pkg::SQ_FIRST;
                end else if (msens == 2'b10 && cfg.directional) begin
                    sq_d = mute_ctrl_pkg::SQ_FAIL;
                end else if (msens == 2'b10) begin
                    sq_d = mute_ctrl_pkg::SQ_FIRST;
                end else if (sens_all) begin
                    sq_d = mute_ctrl_pkg::SQ_FAIL;
                end
            end
            mute_ctrl_pkg::SQ_FIRST: begin
                if (tick)
                    sq_cnt_d = sq_cnt_q + 13'h0001;
                if (sens_all) begin
                    seq_ok = 1'b1;
                end else if (!sens_any) begin
                    sq_d = mute_ctrl_pkg::SQ_IDLE;
                end else if (sq_cnt_q >= 13'(mute_ctrl_pkg::SEQ_WINDOW_TICKS)) begin
                    sq_d = mute_ctrl_pkg::SQ_FAIL;
                end
            end
            mute_ctrl_pkg::SQ_FAIL: begin
                seq_fail = 1'b1;
                if (!sens_any)
                    sq_d = mute_ctrl_pkg::SQ_IDLE;
            end
            default: sq_d = mute_ctrl_pkg::SQ_IDLE;
        endcase
        if (!cfg.mute_enable) begin
            sq_d   = mute_ctrl_pkg::SQ_IDLE;
            seq_ok = 1'b0;
        end
    end

    // Main controller
    mute_ctrl_pkg::ctrl_state_e st_q, st_d;
    logic [12:0] cnt_q, cnt_d;
    logic        fail_stop_q, fail_stop_d;
    logic [7:0]  fb_cnt_q, fb_cnt_d;
    logic        fb_fault;
    logic        outs_on;
    logic        stop_target_ilk;

    // Outputs on in run, mute and bypass; feedback is opposite to outputs
    assign outs_on = (st_q == mute_ctrl_pkg::ST_RUN) || (st_q == mute_ctrl_pkg::ST_MUTE)
                     || (st_q == mute_ctrl_pkg::ST_BYPASS);
    // Feedback must follow the outputs within a short grace time
    always_comb begin
        fb_cnt_d = (fb_s == outs_on) ? fb_cnt_q + 8'h01 : 8'h00;
        fb_fault = (fb_cnt_q >= 8'(FB_GRACE));
        // Saturate only while the mismatch lasts, else lockout could never be left
        if (fb_fault && fb_s == outs_on)
            fb_cnt_d = fb_cnt_q;
    end
    assign stop_target_ilk = (cfg.interlock == mute_ctrl_pkg::ILK_START_RESTART);

    always_comb begin
        st_d        = st_q;
        cnt_d       = (tick && cnt_q != 13'h1FFF) ? cnt_q + 13'h0001 : cnt_q;
        fail_stop_d = fail_stop_q;
        case (st_q)
            mute_ctrl_pkg::ST_POWERUP: begin
                if (cfg.interlock != mute_ctrl_pkg::ILK_AUTO)
                    st_d = mute_ctrl_pkg::ST_INTERLOCK;
                else if (curt_clear)
                    st_d = mute_ctrl_pkg::ST_RUN;
            end
            mute_ctrl_pkg::ST_INTERLOCK: begin
                if (start_rel && curt_clear)
                    st_d = mute_ctrl_pkg::ST_RUN;
            end
            mute_ctrl_pkg::ST_RUN: begin
                fail_stop_d = 1'b0; // Stale sequence failures must not offer a bypass later
                if (seq_ok)
                    st_d = mute_ctrl_pkg::ST_MUTE;
                else if (!curt_clear) begin
                    fail_stop_d = seq_fail;
                    st_d = stop_target_ilk ? mute_ctrl_pkg::ST_INTERLOCK
                                           : mute_ctrl_pkg::ST_STOP;
                end
            end
            mute_ctrl_pkg::ST_MUTE: begin
                if (cfg.mute_limit_en
                    && cnt_q >= 13'(mute_ctrl_pkg::MUTE_LIMIT_TICKS)) begin
                    st_d = mute_ctrl_pkg::ST_BYPASS_OK;
                end else if (!sens_all) begin
                    // Curtain still blocked when sensors drop means a real intrusion
                    st_d = curt_clear ? mute_ctrl_pkg::ST_RUN : mute_ctrl_pkg::ST_STOP;
                end
            end
            mute_ctrl_pkg::ST_STOP: begin
                if (fail_stop_q && sens_any && cfg.mute_enable)
                    st_d = mute_ctrl_pkg::ST_BYPASS_OK;
                else if (curt_clear && cfg.interlock == mute_ctrl_pkg::ILK_AUTO)
                    st_d = mute_ctrl_pkg::ST_RUN;
                else if (curt_clear)
                    st_d = stop_target_ilk ? mute_ctrl_pkg::ST_INTERLOCK
                                           : mute_ctrl_pkg::ST_RUN;
            end
            mute_ctrl_pkg::ST_BYPASS_OK: begin
                if (start_rel)
                    st_d = mute_ctrl_pkg::ST_BYPASS;
                else if (!sens_any && curt_clear)
                    st_d = mute_ctrl_pkg::ST_STOP;
            end
            mute_ctrl_pkg::ST_BYPASS: begin
                // One machine cycle: sensors or curtain clearing ends it
                if (!sens_any || curt_clear
                    || cnt_q >= 13'(mute_ctrl_pkg::BYPASS_MAX_TICKS)) begin
                    fail_stop_d = 1'b0;
                    st_d = mute_ctrl_pkg::ST_STOP;
                end
            end
            default: begin
                // Lockout: a Start release reruns the power-up self-test
                if (start_rel)
                    st_d = mute_ctrl_pkg::ST_POWERUP;
            end
        endcase
        if (fb_fault && st_q != mute_ctrl_pkg::ctrl_state_e'(mute_ctrl_pkg::ST_LOCKOUT_CODE))
            st_d = mute_ctrl_pkg::ctrl_state_e'(mute_ctrl_pkg::ST_LOCKOUT_CODE);
        if (st_d != st_q)
            cnt_d = 13'h0000;
    end

    // Output decode, registered
    logic [1:0]           oss_d;
    mute_ctrl_pkg::lamps_s lamps_d;
    logic [7:0]           diag_d;
    logic                 flash;
    assign flash = (((cnt_q / 13'(mute_ctrl_pkg::FLASH_HALF_TICKS)) & 13'h0001) == 13'h0000);
    always_comb begin
        oss_d   = outs_on ? 2'h3 : 2'h0;
        lamps_d = '0;
        diag_d  = mute_ctrl_pkg::DIAG_LOCKOUT;
        case (st_d)
            mute_ctrl_pkg::ST_POWERUP:   diag_d = mute_ctrl_pkg::DIAG_STOP;
            mute_ctrl_pkg::ST_INTERLOCK: begin
                lamps_d.interlock_yellow = 1'b1;
                lamps_d.stop_red         = 1'b1;
                diag_d = mute_ctrl_pkg::DIAG_INTERLOCK;
            end
            mute_ctrl_pkg::ST_RUN: begin
                lamps_d.run_green = 1'b1;
                diag_d = mute_ctrl_pkg::DIAG_RUN;
            end
            mute_ctrl_pkg::ST_STOP: begin
                lamps_d.stop_red = 1'b1;
                diag_d = mute_ctrl_pkg::DIAG_STOP;
            end
            mute_ctrl_pkg::ST_MUTE, mute_ctrl_pkg::ST_BYPASS: begin
                lamps_d.run_green = 1'b1;
                lamps_d.mute_lamp = 1'b1;
                diag_d = mute_ctrl_pkg::DIAG_MUTE;
            end
            mute_ctrl_pkg::ST_BYPASS_OK: begin
                lamps_d.stop_red  = 1'b1;
                lamps_d.mute_lamp = flash;
                diag_d = mute_ctrl_pkg::DIAG_BYPASS;
            end
            default: lamps_d.stop_red = 1'b1;
        endcase
        // Outputs follow the next state so no stale run cycle is leaked
        oss_d = ((st_d == mute_ctrl_pkg::ST_RUN) || (st_d == mute_ctrl_pkg::ST_MUTE)
                 || (st_d == mute_ctrl_pkg::ST_BYPASS)) ? 2'h3 : 2'h0;
    end

    // State registers
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            start_prev_q            <= 1'b0;
            div_q                   <= 24'h000000;
            sq_q                    <= mute_ctrl_pkg::SQ_IDLE;
            sq_cnt_q                <= 13'h0000;
            st_q                    <= mute_ctrl_pkg::ST_POWERUP;
            cnt_q                   <= 13'h0000;
            fail_stop_q             <= 1'b0;
            fb_cnt_q                <= 8'h00;
            safety_switching_output <= 2'h0;
            lamps                   <= '0;
            diag_code               <= mute_ctrl_pkg::DIAG_STOP;
            lockout                 <= 1'b0;
        end else begin
            start_prev_q            <= start_prev_d;
            div_q                   <= div_d;
            sq_q                    <= sq_d;
            sq_cnt_q                <= sq_cnt_d;
            st_q                    <= st_d;
            cnt_q                   <= cnt_d;
            fail_stop_q             <= fail_stop_d;
            fb_cnt_q                <= fb_cnt_d;
            safety_switching_output <= oss_d;
            lamps                   <= lamps_d;
            diag_code               <= diag_d;
            lockout                 <= (st_d == mute_ctrl_pkg::ctrl_state_e'(
                                        mute_ctrl_pkg::ST_LOCKOUT_CODE));
        end
    end

endmodule

//--- dv/mute_ctrl_properties.sv
// Checker: port-level properties of the mute controller
`timescale 1ns/1ps
module mute_ctrl_properties #(
    parameter int unsigned CURTAINS = 2,
    parameter int unsigned TICK_DIV = 4,
    parameter int unsigned FB_GRACE = 4
) (
    input wire logic                   ref_clk,
    input wire logic                   rst_n,
    input wire logic [CURTAINS-1:0]    light_curtain_in,
    input wire logic [CURTAINS-1:0]    curtain_select,
    input wire logic [1:0]             mute_sensor,
    input wire logic                   start_button,
    input wire logic                   contactor_feedback_monitor,
    input wire mute_ctrl_pkg::config_s cfg,
    input wire logic [1:0]             safety_switching_output,
    input wire mute_ctrl_pkg::lamps_s  lamps,
    input wire logic [7:0]             diag_code,
    input wire logic                   lockout
);
    // Slowest legal flash is 4 ticks per half; one tick of phase slack
    localparam int FLASH_MAX = 5 * TICK_DIV;
    logic        lamp_q;
    logic [15:0] hold_q;
    logic [15:0] hold_d;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    // Cycles the mute lamp stands still while bypass is offered
    always_comb begin
        hold_d = 16'h0000;
        if (diag_code == mute_ctrl_pkg::DIAG_BYPASS && lamps.mute_lamp == lamp_q) begin
            hold_d = hold_q + 16'h0001;
        end
    end
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            hold_q <= 16'h0000;
            lamp_q <= 1'h0;
        end else begin
            hold_q <= hold_d;
            lamp_q <= lamps.mute_lamp;
        end
    end

    // Start press and release seen in a given state
    sequence rel_in_bok;
        diag_code == mute_ctrl_pkg::DIAG_BYPASS && start_button ##1 !start_button;
    endsequence
    sequence rel_in_ilk;
        lamps.interlock_yellow && start_button && &(light_curtain_in | ~curtain_select)
        ##1 !start_button;
    endsequence

    AST_MUTE_ON: assert property (diag_code == mute_ctrl_pkg::DIAG_MUTE |->
        safety_switching_output == 2'h3 && lamps.mute_lamp) else $error("mute without outputs");
    AST_BOK_OFF: assert property (diag_code == mute_ctrl_pkg::DIAG_BYPASS |->
        safety_switching_output == 2'h0) else $error("bypass offer with outputs on");
    AST_FLASH: assert property (int'(hold_q) <= FLASH_MAX)
        else $error("mute lamp flash too slow");
    AST_GRANT: assert property (rel_in_bok |-> ##[1:6] (
        diag_code == mute_ctrl_pkg::DIAG_MUTE && safety_switching_output == 2'h3
        && lamps.mute_lamp)) else $error("bypass not granted");
    AST_START_RUN: assert property (rel_in_ilk |-> ##[1:6] lamps.run_green)
        else $error("start did not leave interlock");
    // Two sync flops plus the grace count give six mismatched samples before lockout
    AST_FB: assert property (
        (contactor_feedback_monitor == safety_switching_output[0])[*6] |-> ##[0:8] lockout)
        else $error("feedback mismatch ignored");
    AST_ILK: assert property (lamps.interlock_yellow |->
        lamps.stop_red && !lamps.run_green && safety_switching_output == 2'h0)
        else $error("interlock indicators wrong");
    AST_RUN: assert property (lamps.run_green |-> safety_switching_output == 2'h3
        && !lamps.stop_red && !lamps.interlock_yellow) else $error("run indicators wrong");
    AST_STOP: assert property (diag_code == mute_ctrl_pkg::DIAG_STOP && !lockout |->
        safety_switching_output == 2'h0 && !lamps.run_green) else $error("stop with outputs on");
    AST_LOCK: assert property (lockout |-> safety_switching_output == 2'h0)
        else $error("lockout with outputs on");
endmodule

bind light_curtain_mute_controller mute_ctrl_properties #(
    .CURTAINS(CURTAINS), .TICK_DIV(TICK_DIV), .FB_GRACE(FB_GRACE)
) u_props (
    .ref_clk(ref_clk), .rst_n(rst_n), .light_curtain_in(light_curtain_in),
    .curtain_select(curtain_select), .mute_sensor(mute_sensor), .start_button(start_button),
    .contactor_feedback_monitor(contactor_feedback_monitor), .cfg(cfg),
    .safety_switching_output(safety_switching_output), .lamps(lamps),
    .diag_code(diag_code), .lockout(lockout)
);

//--- dv/machine_side_model.sv
// Guarded machine model: contactor follows the safety outputs
`timescale 1ns/1ps
module machine_side_model (
    input  wire logic       ref_clk,
    input  wire logic [1:0] safety_switching_output,
    input  wire logic       stuck_open,
    output logic            contactor_feedback_monitor
);
    logic open_q = 1'h1;
    // Contactor settles a cycle late; a stuck coil never pulls in
    always @(posedge ref_clk) begin
        open_q <= stuck_open | ~(&safety_switching_output);
    end
    assign contactor_feedback_monitor = open_q;
endmodule

//--- dv/testbench.sv
// Self-checking bench for the light curtain mute controller
`timescale 1ns/1ps
module testbench;
    localparam logic [14:0] RUNV  = {2'h3, 4'h8, mute_ctrl_pkg::DIAG_RUN, 1'h0};
    localparam logic [14:0] STOPV = {2'h0, 4'h4, mute_ctrl_pkg::DIAG_STOP, 1'h0};
    localparam logic [14:0] ILKV  = {2'h0, 4'h6, mute_ctrl_pkg::DIAG_INTERLOCK, 1'h0};
    localparam logic [14:0] MUTEV = {2'h3, 4'h1, mute_ctrl_pkg::DIAG_MUTE, 1'h0};
    localparam logic [14:0] BOKV  = {2'h0, 4'h0, mute_ctrl_pkg::DIAG_BYPASS, 1'h0};
    localparam logic [14:0] LOCKV = 15'h0001;
    // Masks: mute states leave green/red open, bypass offer the flashing lamp
    localparam logic [14:0] ALL = 15'h7FFF;
    localparam logic [14:0] MM  = 15'h63FF;
    localparam logic [14:0] MB  = 15'h61FF;
    localparam logic [14:0] ML  = 15'h6001;
    logic                   ref_clk, rst_n, start_button, stuck, fb, lockout;
    logic [1:0]             lc, sel, ms, outs;
    logic [7:0]             diag_code;
    mute_ctrl_pkg::config_s cfg;
    mute_ctrl_pkg::lamps_s  lamps;
    int                     errors, checks_done;
    wire  [14:0]            status = {outs, lamps, diag_code, lockout};

    light_curtain_mute_controller #(.CURTAINS(2), .TICK_DIV(4), .FB_GRACE(4)) i_dut (
        .ref_clk(ref_clk), .rst_n(rst_n), .light_curtain_in(lc), .curtain_select(sel),
        .mute_sensor(ms), .start_button(start_button), .contactor_feedback_monitor(fb),
        .cfg(cfg), .safety_switching_output(outs), .lamps(lamps), .diag_code(diag_code),
        .lockout(lockout));
    machine_side_model i_machine (.ref_clk(ref_clk), .safety_switching_output(outs),
        .stuck_open(stuck), .contactor_feedback_monitor(fb));

    initial begin
        ref_clk = 1'h0;
        forever #4 ref_clk = ~ref_clk;
    end

    task automatic step(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    task automatic stop_test();
        if (errors == 0 && checks_done > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic fail(input string what, input logic [14:0] exp);
        errors++;
        $display("[FAIL] %s expected %h seen %h", what, exp, status);
    endtask
    // Bounded wait, sampled mid-cycle; a wait that runs out ends the run
    task automatic wait_st(input string what, input logic [14:0] exp, input logic [14:0] m,
                           input int lim);
        checks_done++;
        for (int i = 0; i < lim && (status & m) !== exp; i++) @(negedge ref_clk);
        if ((status & m) !== exp) begin
            fail(what, exp);
            stop_test();
        end
        @(posedge ref_clk); // Next stimulus lands on a rising edge
    endtask
    task automatic hold_st(input string what, input logic [14:0] exp, input logic [14:0] m,
                           input int n);
        checks_done++;
        for (int i = 0; i < n; i++) begin
            @(negedge ref_clk);
            if ((status & m) !== exp) begin
                fail(what, exp);
                i = n;
            end
        end
        @(posedge ref_clk); // Next stimulus lands on a rising edge
    endtask
    // Full press and release, long enough to pass the input synchroniser
    task automatic press();
        step(1);
        start_button <= 1'h1;
        step(6);
        start_button <= 1'h0;
    endtask
    task automatic sense(input logic [1:0] a, input logic [1:0] b);
        step(1);
        ms <= a;
        step(4);
        ms <= b;
    endtask
    task automatic restart(input logic lim, input logic dir,
                           input mute_ctrl_pkg::interlock_mode_e m);
        step(1);
        rst_n <= 1'h0;
        cfg <= '{1'h1, lim, dir, m};
        step(10);
        rst_n <= 1'h1;
    endtask
    // Lamp toggles over 40 ticks: 1 Hz gives 10, 2 Hz gives 20
    task automatic flash();
        int t;
        logic l;
        t = 0;
        l = lamps.mute_lamp;
        checks_done++;
        repeat (160) begin
            @(negedge ref_clk);
            if (lamps.mute_lamp !== l) t++;
            l = lamps.mute_lamp;
        end
        if (t < 9 || t > 21) begin
            errors++;
            $display("[FAIL] flash toggles expected 9..21 seen %0d", t);
        end
    endtask

    // Main sequence: muting, timed bypass, direction, interlock modes, lockout
    initial begin
        {rst_n, start_button, stuck, ms, errors, checks_done} = '0;
        {lc, sel} = 4'hF;
        cfg = '0;
        restart(1'h1, 1'h0, mute_ctrl_pkg::ILK_START);
        wait_st("interlock", ILKV, ALL, 40);
        hold_st("interlock", ILKV, ALL, 20);
        press();
        wait_st("run", RUNV, ALL, 20);
        for (int k = 0; k < 2; k++) begin
            sense(2'h1, 2'h3);
            wait_st("mute", MUTEV, MM, 20);
            lc <= 2'h1;
            hold_st("muted blocked", MUTEV, MM, 3700);
            wait_st("bypass offer", BOKV, MB, 200);
            if (k == 0) flash();
            press();
            wait_st("bypass", MUTEV, MM, 20);
            if (k == 1) hold_st("bypass", MUTEV, MM, 19000);
            if (k == 0) ms <= 2'h0;
            wait_st("bypass end", STOPV, ALL, 400);
            step(1);
            {lc, ms} <= 4'hC;
            wait_st("run again", RUNV, ALL, 20);
        end
        restart(1'h0, 1'h1, mute_ctrl_pkg::ILK_START);
        press();
        wait_st("run", RUNV, ALL, 60);
        sense(2'h2, 2'h3);
        lc <= 2'h1;
        wait_st("wrong order", BOKV, MB, 40);
        press();
        wait_st("bypass", MUTEV, MM, 20);
        lc <= 2'h3;
        wait_st("curtain clear", RUNV, ALL, 20);
        ms <= 2'h0;
        hold_st("idle", RUNV, ALL, 10);
        sense(2'h1, 2'h3);
        wait_st("right order", MUTEV, MM, 20);
        ms <= 2'h0;
        wait_st("mute end", RUNV, ALL, 20);
        restart(1'h0, 1'h0, mute_ctrl_pkg::ILK_START_RESTART);
        press();
        wait_st("run", RUNV, ALL, 60);
        lc <= 2'h1;
        wait_st("restart lock", ILKV, ALL, 20);
        lc <= 2'h3;
        hold_st("restart lock", ILKV, ALL, 40);
        press();
        wait_st("restarted", RUNV, ALL, 20);
        {sel, lc} <= 4'h5;
        restart(1'h0, 1'h0, mute_ctrl_pkg::ILK_AUTO);
        wait_st("auto run", RUNV, ALL, 40);
        sel <= 2'h3;
        wait_st("stop", STOPV, ALL, 20);
        lc <= 2'h3;
        wait_st("auto rerun", RUNV, ALL, 20);
        stuck <= 1'h1;
        wait_st("lockout", LOCKV, ML, 40);
        hold_st("lockout", LOCKV, ML, 20);
        stuck <= 1'h0;
        press();
        wait_st("self-test", RUNV, ALL, 80);
        stop_test();
    end
endmodule
